// ---- shared/wdog_pkg.sv ----
// Constants shared by the window watchdog design
package wdog_pkg;
  // Internal oscillator period equals one fault pulse time
  localparam int unsigned OSC_PERIOD_NS = 50000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Clock cycles per oscillator tick, rounded down, at least one
  localparam int unsigned TICK_CYCLES_RAW = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CYCLES =
    (TICK_CYCLES_RAW < 1) ? 1 : TICK_CYCLES_RAW;
  // Window period in oscillator ticks
  localparam int unsigned WINDOW_TICKS = 5000;
  localparam int unsigned HALF_TICKS = WINDOW_TICKS / 2;
  // First open window after initialization, in window periods
  localparam int unsigned FIRST_OPEN_MULT = 8;
  localparam int unsigned FIRST_OPEN_TICKS = FIRST_OPEN_MULT * WINDOW_TICKS;
  // Fault pulse length in ticks
  localparam int unsigned FAULT_TICKS = 1;
  localparam int TICK_W = 16;
  localparam int CNT_W = 16;
endpackage

// ---- src/window_watchdog.sv ----
// Window watchdog with pulsed fault or latched flag output option
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Fault when no kick arrives in the extended first open window.
// - Pulsed option: fault drives fault output low for one pulse time.
// - Supervisor reset rising while enabled reinitializes the watchdog.
// - Pulsed option: disabling never shortens an active fault pulse.
// - Enable falling edge reinitializes when supervisor reset is high.
// - Flag option: unserviced first open window sets a latched flag.
// - Flag option: supervisor reset pulses low one pulse time at flag set.
// - Flag option: supervisor reset low from output drop clears the flag.
// - Flag option: disabling the watchdog keeps the flag set.
// - Flag option: disabling never shortens the fault reset pulse.
// - Re-enabling via enable high then low reinitializes supervision.
// - First open window is eight windows; later open windows half one.
// - Each regular window is a closed half then an open half.
// - Kick in closed window or missing kick in open window is a fault.
module window_watchdog
  import wdog_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flag_option,
  input wire logic wdog_enable_n,
  input wire logic service_kick,
  input wire logic regulator_good,
  output logic service_fault_pulse_n,
  output logic service_fault_latch,
  output logic supervisor_reset_n
);

  typedef enum logic [1:0] {IDLE, FIRST_OPEN, CLOSED, OPEN} phase_e;

  logic [1:0] en_sync_r;
  logic [1:0] kick_sync_r;
  logic [1:0] good_sync_r;
  logic [1:0] opt_sync_r;
  logic en_prev_r;
  logic kick_prev_r;
  logic rst_prev_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick;
  phase_e phase_r;
  logic [CNT_W-1:0] win_cnt_r;
  logic [CNT_W-1:0] win_cnt_nxt;
  logic [CNT_W-1:0] pulse_cnt_r;
  logic pulse_active;
  logic fault;
  logic reinit;
  logic enabled;
  logic kick_rise;
  logic sup_rise;
  logic en_fall;

  // Two-stage synchronisers on all pin inputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      en_sync_r <= 2'h0;
      kick_sync_r <= 2'h0;
      good_sync_r <= 2'h0;
      opt_sync_r <= 2'h0;
    end
    else
    begin
      en_sync_r <= {en_sync_r[0], wdog_enable_n};
      kick_sync_r <= {kick_sync_r[0], service_kick};
      good_sync_r <= {good_sync_r[0], regulator_good};
      opt_sync_r <= {opt_sync_r[0], flag_option};
    end
  end

  // Enable pin is active low, so reset state means enabled
  assign enabled = !en_sync_r[1];

  // Edge history from the second synchroniser stage, plus the supervisor reset output
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      en_prev_r <= 1'b0;
      kick_prev_r <= 1'b0;
      rst_prev_r <= 1'b0;
    end
    else
    begin
      en_prev_r <= en_sync_r[1];
      kick_prev_r <= kick_sync_r[1];
      rst_prev_r <= supervisor_reset_n;
    end
  end

  assign kick_rise = kick_sync_r[1] && !kick_prev_r;
  assign sup_rise = supervisor_reset_n && !rst_prev_r;
  assign en_fall = !en_sync_r[1] && en_prev_r;

  // Oscillator tick divider; stands in for the resistor-set oscillator
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tick_cnt_r <= '0;
    else if (tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + TICK_W'(1);
  end

  assign tick = (tick_cnt_r == TICK_W'(TICK_LEN - 1));

  // Reinit on supervisor reset rise while enabled, or enable fall
  assign reinit = (sup_rise && enabled)
    || (en_fall && supervisor_reset_n);

  // Fault on missed open window or kick in closed window
  always_comb
  begin
    fault = 1'b0;
    win_cnt_nxt = win_cnt_r;
    if (tick)
      win_cnt_nxt = win_cnt_r + CNT_W'(1);
    unique case (phase_r)
      IDLE:
        fault = 1'b0;
      FIRST_OPEN:
        fault = tick && !kick_rise
          && (win_cnt_r == CNT_W'(FIRST_OPEN_TICKS - 1));
      CLOSED:
        fault = kick_rise;
      OPEN:
        fault = tick && !kick_rise
          && (win_cnt_r == CNT_W'(HALF_TICKS - 1));
    endcase
  end

  // Window sequencer; any fault reinitializes to the long first window
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_r <= IDLE;
      win_cnt_r <= '0;
    end
    else if (!enabled || !supervisor_reset_n)
    begin
      phase_r <= IDLE;
      win_cnt_r <= '0;
    end
    else if (reinit || fault || phase_r == IDLE)
    begin
      phase_r <= FIRST_OPEN;
      win_cnt_r <= '0;
    end
    else if (kick_rise && (phase_r == FIRST_OPEN || phase_r == OPEN))
    begin
      phase_r <= CLOSED;
      win_cnt_r <= '0;
    end
    else if (phase_r == CLOSED && tick
      && win_cnt_r == CNT_W'(HALF_TICKS - 1))
    begin
      phase_r <= OPEN;
      win_cnt_r <= '0;
    end
    else
      win_cnt_r <= win_cnt_nxt;
  end

  // Pulse timer runs to completion whatever the enable does
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pulse_cnt_r <= '0;
    else if (fault)
      pulse_cnt_r <= CNT_W'(FAULT_TICKS * TICK_LEN);
    else if (pulse_cnt_r != '0)
      pulse_cnt_r <= pulse_cnt_r - CNT_W'(1);
  end

  assign pulse_active = (pulse_cnt_r != '0) || fault;

  // Pulsed fault output, only in the pulsed option
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      service_fault_pulse_n <= 1'b1;
    else
      service_fault_pulse_n <= !(pulse_active && !opt_sync_r[1]);
  end

  // Supervisor reset: regulator drop, or fault pulse in flag option
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      supervisor_reset_n <= 1'b0;
    else
      supervisor_reset_n <= good_sync_r[1]
        && !(pulse_active && opt_sync_r[1]);
  end

  // Latched flag; set wins, cleared only by regulator-caused reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      service_fault_latch <= 1'b0;
    else if (fault && opt_sync_r[1])
      service_fault_latch <= 1'b1;
    else if (!good_sync_r[1])
      service_fault_latch <= 1'b0;
    // Disable leaves the flag untouched
  end

  // Low-time counters for the pulse length checks
  // A real tick is far too long for a repetition, so count cycles instead
  logic [CNT_W-1:0] fault_low_r;
  logic [CNT_W-1:0] rst_low_r;

  // Counters restart whenever their output is high again
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fault_low_r <= '0;
      rst_low_r <= '0;
    end
    else
    begin
      fault_low_r <= service_fault_pulse_n ? '0 : fault_low_r + CNT_W'(1);
      rst_low_r <= supervisor_reset_n ? '0 : rst_low_r + CNT_W'(1);
    end
  end

  // Fault pulse lasts the decision cycle plus one tick time
  a_pulse_len: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(service_fault_pulse_n) |->
      fault_low_r == CNT_W'(FAULT_TICKS * TICK_LEN + 1))
    else $error("fault pulse length wrong");

  // Flag-option reset pulse has the same length, enable or not
  // Only pulses that end with the flag still set come from a fault
  a_rst_pulse_len: assert property (@(posedge clk) disable iff (!reset_n)
    ($rose(supervisor_reset_n) && service_fault_latch && opt_sync_r[1]) |->
      rst_low_r == CNT_W'(FAULT_TICKS * TICK_LEN + 1))
    else $error("fault reset pulse length wrong");

  // Disable does not cut the pulse short
  a_pulse_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (!service_fault_pulse_n && pulse_cnt_r > 1) |=> !service_fault_pulse_n)
    else $error("fault pulse cut short");

  // Flag set comes with a reset pulse
  a_flag_reset: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(service_fault_latch) |-> !supervisor_reset_n)
    else $error("flag set without reset pulse");

  // Flag survives disable while regulator is good
  a_flag_keep: assert property (@(posedge clk) disable iff (!reset_n)
    (service_fault_latch && good_sync_r[1]) |=> service_fault_latch)
    else $error("flag lost");

  // Regulator drop clears the flag
  a_flag_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (!good_sync_r[1] && !fault) |=> !service_fault_latch)
    else $error("flag not cleared");

  // Reinit enters the first open window
  a_reinit_first: assert property (@(posedge clk) disable iff (!reset_n)
    (reinit && enabled && supervisor_reset_n) |=> phase_r == FIRST_OPEN)
    else $error("reinit missed");

  // Kick during closed half is a fault
  a_closed_kick: assert property (@(posedge clk) disable iff (!reset_n)
    (phase_r == CLOSED && kick_rise) |-> fault)
    else $error("closed kick not faulted");

  // First window bounded by eight windows
  a_first_len: assert property (@(posedge clk) disable iff (!reset_n)
    phase_r == FIRST_OPEN |-> win_cnt_r < CNT_W'(FIRST_OPEN_TICKS))
    else $error("first window overrun");

endmodule
`default_nettype wire

// ---- bench/mcu_model.sv ----
// Controller model that enables and services the watchdog
`timescale 1ns/1ns
`default_nettype none
module mcu_model
#(
  parameter int unsigned HOLD_CYCLES = 3
)
(
  input wire logic clk,
  output logic service_kick,
  output logic wdog_enable_n
);
  int hold_left;

  // Idle: kick low, watchdog disabled until told otherwise
  initial
  begin
    service_kick = 1'b0;
    wdog_enable_n = 1'b1;
    hold_left = 0;
  end

  // Kick only when the bench asks; extra cycle covers update order
  task automatic kick();
    @(negedge clk);
    service_kick = 1'b1;
    hold_left = HOLD_CYCLES + 1;
  endtask

  // Called at a falling edge; high then low restarts supervision
  task automatic set_enable(input logic on);
    wdog_enable_n = ~on;
  endtask

  // Release kick only after the full hold time
  always @(negedge clk)
  begin
    if (hold_left > 0)
    begin
      hold_left = hold_left - 1;
      if (hold_left == 0)
        service_kick = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- bench/window_watchdog_fault_reinit_test.sv ----
// Self-checking bench for watchdog fault and reinitialization
`timescale 1ns/1ns
`default_nettype none
`define check_eq(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module window_watchdog_fault_reinit_test;
  import wdog_pkg::*;
  // One clock per tick keeps the long first window inside the budget
  localparam int TL = 1;
  localparam int FIRST = FIRST_OPEN_TICKS * TL;
  localparam int HALF = HALF_TICKS * TL;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic flag_option = 1'b0;
  logic regulator_good = 1'b1;
  logic service_kick;
  logic wdog_enable_n;
  logic service_fault_pulse_n;
  logic service_fault_latch;
  logic supervisor_reset_n;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  mcu_model #(.HOLD_CYCLES(3 * TL)) mcu (.clk(clk),
    .service_kick(service_kick), .wdog_enable_n(wdog_enable_n));

  window_watchdog #(.TICK_LEN(TL)) dut (.clk(clk), .reset_n(reset_n),
    .flag_option(flag_option), .wdog_enable_n(wdog_enable_n),
    .service_kick(service_kick), .regulator_good(regulator_good),
    .service_fault_pulse_n(service_fault_pulse_n),
    .service_fault_latch(service_fault_latch),
    .supervisor_reset_n(supervisor_reset_n));

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cycles until either fault indication appears must fall in lo..hi
  task automatic expect_fault(input int lo, input int hi);
    int n;
    n = 0;
    while (service_fault_pulse_n !== 1'b0 && service_fault_latch !== 1'b1
           && n <= hi)
    begin
      @(negedge clk);
      n++;
    end
    `check_eq("fault_time_ok", 1'b1, (n >= lo && n <= hi))
  endtask

  // Length of a low pulse on the fault output or the supervisor reset
  task automatic low_len(input logic sel, input int exp);
    int n;
    n = 0;
    while ((sel ? supervisor_reset_n : service_fault_pulse_n) === 1'b0
           && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    `check_eq("low_cycles", exp, n)
  endtask

  task automatic quiet(input int len);
    int f;
    f = 0;
    repeat (len)
    begin
      @(negedge clk);
      if (service_fault_pulse_n === 1'b0 || service_fault_latch === 1'b1)
        f++;
    end
    `check_eq("fault_free", 0, f)
  endtask

  // Pulsed option: unserviced first window, disable inside the pulse
  task automatic first_window_pulsed();
    mcu.set_enable(1'b1);
    expect_fault(FIRST - 16, FIRST + 16);
    mcu.set_enable(1'b0);
    low_len(1'b0, TL + 1);
  endtask

  // Re-enable, serve an open window, miss one, then kick while closed
  task automatic kicked_windows();
    mcu.set_enable(1'b1);
    repeat (20) @(negedge clk);
    mcu.kick();
    quiet(HALF + 30);
    mcu.kick();
    expect_fault(2 * HALF - 16, 2 * HALF + 16);
    low_len(1'b0, TL + 1);
    mcu.kick();
    repeat (100) @(negedge clk);
    mcu.kick();
    expect_fault(0, 16);
    low_len(1'b0, TL + 1);
  endtask

  // Flag option: regulator dip restarts, flag latches, dip clears it
  task automatic flag_option_path();
    flag_option = 1'b1;
    repeat (200) @(negedge clk);
    regulator_good = 1'b0;
    repeat (10) @(negedge clk);
    regulator_good = 1'b1;
    expect_fault(FIRST - 16, FIRST + 24);
    `check_eq("latch_set", 1'b1, service_fault_latch)
    `check_eq("pulse_idle", 1'b1, service_fault_pulse_n)
    mcu.set_enable(1'b0);
    low_len(1'b1, TL + 1);
    repeat (20) @(negedge clk);
    `check_eq("latch_kept", 1'b1, service_fault_latch)
    regulator_good = 1'b0;
    repeat (6) @(negedge clk);
    `check_eq("latch_cleared", 1'b0, service_fault_latch)
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    first_window_pulsed();
    kicked_windows();
    flag_option_path();
    complete_run();
  end
endmodule
`default_nettype wire
